// File: verilog/pcs_port_clock_top.sv
// port clock sourcing: straps, port-6 clock direction, sync clock, registers
//
// Register access over AHB-Lite and the register offsets were left to the implementer.
`timescale 1ns/1ns
module pcs_port_clock_top (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic osc_in,
    output logic osc_out,
    input wire logic p6_receive_clock_in,
    output logic p6_receive_clock_out,
    output logic p6_receive_clock_oe,
    input wire logic p6_transmit_clock_in,
    output logic p6_transmit_clock_out,
    output logic p6_transmit_clock_oe,
    input wire logic p6_rmii_ref_input,
    output logic p6_rmii_ref_output,
    input wire logic mgmt_clock_in,
    input wire logic [pcs_pkg::NUM_PHY-1:0] phy_recovered_clock,
    input wire logic [1:0] strap_p6_mode,
    input wire logic strap_mii_phy_role,
    input wire logic strap_rmii_clock_mode,
    input wire logic strap_rgmii_gig,
    output logic sync_ether_clock_out,
    output logic core_clock_ok,
    output logic ref_tick,
    output logic p6_in_clock_rise,
    output logic mgmt_clock_rise
);
    // ------------------------------
    // pin synchronisers
    // ------------------------------
    logic [pcs_pkg::NUM_PINS-1:0] pin_s1_q;
    logic [pcs_pkg::NUM_PINS-1:0] pin_s2_q;
    logic [pcs_pkg::NUM_PINS-1:0] pin_s3_q;
    wire [pcs_pkg::NUM_PINS-1:0] pins = {strap_rgmii_gig, strap_rmii_clock_mode,
        strap_mii_phy_role, strap_p6_mode, phy_recovered_clock, mgmt_clock_in,
        p6_rmii_ref_input, p6_transmit_clock_in, p6_receive_clock_in, osc_in};
    always_ff @(posedge clock) begin
        if (rst) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            pin_s3_q <= '0;
        end else if (ce) begin
            pin_s1_q <= pins;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end
    wire [pcs_pkg::NUM_PINS-1:0] pin_rise = pin_s2_q & ~pin_s3_q;
    wire ref_lvl = pin_s2_q[0];
    wire [pcs_pkg::NUM_PHY-1:0] rec_lvl = pin_s2_q[9:5];
    wire [4:0] strap_now = pin_s2_q[14:10];

    // ------------------------------
    // reference and crystal
    // ------------------------------
    // oscillator amplifier sits on the pin path; a flop here would stop the crystal
    assign osc_out = ~osc_in;
    logic [4:0] ref_gap_q;
    logic ref_ok_q;
    logic ref_tick_q;
    always_ff @(posedge clock) begin
        if (rst) begin
            ref_gap_q <= 5'h0;
            ref_ok_q <= 1'b0;
            ref_tick_q <= 1'b0;
        end else if (ce) begin
            ref_tick_q <= pin_rise[0];
            if (pin_rise[0]) begin
                ref_gap_q <= 5'h0;
                ref_ok_q <= 1'b1;
            end else if (ref_gap_q == pcs_pkg::REF_LOSS_CYC) begin
                ref_ok_q <= 1'b0;
            end else begin
                ref_gap_q <= ref_gap_q + 5'h1;
            end
        end
    end
    // no port-7 clock pin exists; serial receive recovers its own clock
    assign ref_tick = ref_tick_q;
    assign core_clock_ok = ref_ok_q;

    // ------------------------------
    // strap capture
    // ------------------------------
    logic [1:0] strap_cnt_q;
    logic straps_valid_q;
    pcs_pkg::pcs_mode_t mode_q;
    logic phy_role_q;
    logic rmii_clk_mode_q;
    logic rgmii_gig_q;
    wire pcs_pkg::pcs_mode_t strap_mode = strap_now[1] ? pcs_pkg::PCS_RGMII :
        strap_now[0] ? pcs_pkg::PCS_RMII : pcs_pkg::PCS_MII;
    // waits for the synchroniser to fill, then freezes until next reset
    always_ff @(posedge clock) begin
        if (rst) begin
            strap_cnt_q <= 2'h0;
            straps_valid_q <= 1'b0;
            mode_q <= pcs_pkg::PCS_MII;
            phy_role_q <= 1'b0;
            rmii_clk_mode_q <= 1'b0;
            rgmii_gig_q <= 1'b0;
        end else if (ce && !straps_valid_q) begin
            if (strap_cnt_q == pcs_pkg::STRAP_SETTLE) begin
                straps_valid_q <= 1'b1;
                mode_q <= strap_mode;
                phy_role_q <= strap_now[2];
                rmii_clk_mode_q <= strap_now[3];
                rgmii_gig_q <= strap_now[4];
            end else begin
                strap_cnt_q <= strap_cnt_q + 2'h1;
            end
        end
    end
    wire is_mii = mode_q == pcs_pkg::PCS_MII;
    wire is_rmii = mode_q == pcs_pkg::PCS_RMII;
    wire is_rgmii = mode_q == pcs_pkg::PCS_RGMII;

    // ------------------------------
    // register bus
    // ------------------------------
    logic [4:0] out_clk_q;
    logic p6_slow_q;
    logic dph_q;
    logic dwr_q;
    logic rwait_q;
    logic [7:0] daddr_q;
    logic [31:0] hrdata_q;
    wire gsw_busy;
    wire addr_ok = hsel && hready && htrans[1];
    wire [31:0] rd_word = (daddr_q == pcs_pkg::ADDR_OUT_CLK) ? {27'h0, out_clk_q} :
        (daddr_q == pcs_pkg::ADDR_P6_CTRL) ? {31'h0, p6_slow_q} :
        (daddr_q == pcs_pkg::ADDR_STATUS) ? {22'h0, core_clock_ok, gsw_busy,
        rgmii_gig_q, rmii_clk_mode_q, phy_role_q, mode_q, 2'h0, straps_valid_q} : 32'h0;
    wire wr_now = dph_q && dwr_q;
    wire wr_oc = wr_now && daddr_q == pcs_pkg::ADDR_OUT_CLK;
    wire wr_p6 = wr_now && daddr_q == pcs_pkg::ADDR_P6_CTRL;
    // reads add one wait state so read data always leaves a flop
    assign hreadyout = !(dph_q && !dwr_q && !rwait_q);
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    always_ff @(posedge clock) begin
        if (rst) begin
            dph_q <= 1'b0;
            dwr_q <= 1'b0;
            rwait_q <= 1'b0;
            daddr_q <= 8'h0;
            hrdata_q <= 32'h0;
        end else if (ce) begin
            if (dph_q && !dwr_q && !rwait_q) begin
                hrdata_q <= rd_word;
                rwait_q <= 1'b1;
            end else begin
                rwait_q <= 1'b0;
                dph_q <= addr_ok;
                dwr_q <= hwrite;
                daddr_q <= {haddr[7:2], 2'h0};
            end
        end
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            out_clk_q <= pcs_pkg::OUT_CLK_RST;
            p6_slow_q <= pcs_pkg::P6_SLOW_RST;
        end else if (ce) begin
            if (wr_oc) out_clk_q <= hwdata[4:0];
            if (wr_p6) p6_slow_q <= hwdata[pcs_pkg::P6_SLOW_BIT];
        end
    end

    // ------------------------------
    // port-6 clock generation
    // ------------------------------
    logic [5:0] div_cnt_q;
    logic port_clk_q;
    logic fast_q;
    wire [5:0] half_mii = p6_slow_q ? pcs_pkg::HALF_10 : pcs_pkg::HALF_100;
    wire [5:0] half_rgmii = p6_slow_q ? pcs_pkg::HALF_10 :
        rgmii_gig_q ? pcs_pkg::HALF_GIG : pcs_pkg::HALF_100;
    wire [5:0] half_sel = is_rgmii ? half_rgmii : is_rmii ? pcs_pkg::HALF_RMII : half_mii;
    always_ff @(posedge clock) begin
        if (rst) begin
            div_cnt_q <= 6'h0;
            port_clk_q <= 1'b0;
            fast_q <= 1'b0;
        end else if (ce) begin
            fast_q <= ~fast_q;
            if (div_cnt_q + 6'h1 >= half_sel) begin
                div_cnt_q <= 6'h0;
                port_clk_q <= ~port_clk_q;
            end else begin
                div_cnt_q <= div_cnt_q + 6'h1;
            end
        end
    end
    wire drive_rx = straps_valid_q && ((is_mii && phy_role_q) || is_rgmii);
    wire drive_tx = straps_valid_q && is_mii && phy_role_q;
    wire drive_ref = straps_valid_q && is_rmii && rmii_clk_mode_q;
    assign p6_receive_clock_oe = drive_rx;
    assign p6_transmit_clock_oe = drive_tx;
    assign p6_receive_clock_out = port_clk_q;
    assign p6_transmit_clock_out = port_clk_q;
    assign p6_rmii_ref_output = drive_ref & port_clk_q;
    // port-6 clock entering the device in the current mode
    wire in_rise = is_rgmii ? pin_rise[2] :
        is_rmii ? pin_rise[3] & !rmii_clk_mode_q : pin_rise[1] & !phy_role_q;
    logic in_rise_q;
    logic mgmt_rise_q;
    always_ff @(posedge clock) begin
        if (rst) begin
            in_rise_q <= 1'b0;
            mgmt_rise_q <= 1'b0;
        end else if (ce) begin
            in_rise_q <= straps_valid_q & in_rise;
            mgmt_rise_q <= pin_rise[4];
        end
    end
    assign p6_in_clock_rise = in_rise_q;
    assign mgmt_clock_rise = mgmt_rise_q;

    // ------------------------------
    // synchronous clock output
    // ------------------------------
    pcs_gsw_if gsw ();
    wire [2:0] oc_src = out_clk_q[4:2];
    wire src_ref = oc_src == 3'h0 || oc_src > 3'(pcs_pkg::NUM_PHY);
    assign gsw.cand = {rec_lvl, fast_q, ref_lvl};
    assign gsw.sel = src_ref ? {2'h0, out_clk_q[pcs_pkg::OC_FAST_BIT]} :
        oc_src + 3'h1;
    assign gsw.en = out_clk_q[pcs_pkg::OC_EN_BIT];
    assign gsw_busy = gsw.busy;
    assign sync_ether_clock_out = gsw.clk_out;
    pcs_sync_clk_sel u_sel (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .sw(gsw.gen)
    );

    // ------------------------------
    // checks
    // ------------------------------
    mac_role_inputs_a: assert property (@(posedge clock) disable iff (rst)
        straps_valid_q && is_mii && !phy_role_q |-> !p6_receive_clock_oe && !p6_transmit_clock_oe)
        else $error("mii mac role drives a port clock");
    rgmii_dirs_a: assert property (@(posedge clock) disable iff (rst)
        straps_valid_q && is_rgmii |-> p6_receive_clock_oe && !p6_transmit_clock_oe)
        else $error("rgmii clock directions wrong");
    straps_frozen_a: assert property (@(posedge clock) disable iff (rst)
        straps_valid_q |=> straps_valid_q && $stable(mode_q) && $stable(phy_role_q))
        else $error("latched straps changed");
    rmii_ref_off_a: assert property (@(posedge clock) disable iff (rst)
        !(is_rmii && rmii_clk_mode_q) |-> !p6_rmii_ref_output)
        else $error("rmii reference driven in normal mode");
    read_wait_a: assert property (@(posedge clock) disable iff (rst || !ce)
        addr_ok && !hwrite && hreadyout ##1 ce |-> !hreadyout ##1 hreadyout)
        else $error("read wait state not exactly one cycle");
    oc_write_a: assert property (@(posedge clock) disable iff (rst)
        wr_oc && ce |=> out_clk_q == $past(hwdata[4:0]))
        else $error("output clock control write lost");
endmodule : pcs_port_clock_top

// File: inc/pcs_pkg.sv
// constants and types for port clock sourcing
package pcs_pkg;
    // ------------------------------
    // register map
    // ------------------------------
    localparam logic [7:0] ADDR_OUT_CLK = 8'h00;
    localparam logic [7:0] ADDR_P6_CTRL = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam int OC_EN_BIT = 0;
    localparam int OC_FAST_BIT = 1;
    localparam int OC_SRC_LSB = 2;
    localparam logic [4:0] OUT_CLK_RST = 5'h01;
    localparam int P6_SLOW_BIT = 0;
    localparam logic P6_SLOW_RST = 1'h0;
    // ------------------------------
    // clocking figures
    // ------------------------------
    localparam int NUM_PHY = 5;
    localparam int NUM_CAND = NUM_PHY + 2;
    localparam int NUM_PINS = 15;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;
    localparam int CLK_NS = 100;
    localparam int REF_LOSS_NS = 1600;
    localparam logic [4:0] REF_LOSS_CYC = 5'(REF_LOSS_NS / CLK_NS);
    // port-6 clock half periods in core cycles, ratios kept
    localparam logic [5:0] HALF_GIG = 6'h01;
    localparam logic [5:0] HALF_100 = 6'h05;
    localparam logic [5:0] HALF_10 = 6'h32;
    localparam logic [5:0] HALF_RMII = 6'h01;
    typedef enum logic [1:0] {PCS_MII, PCS_RMII, PCS_RGMII} pcs_mode_t;
    typedef enum logic [1:0] {GS_RUN, GS_DRAIN, GS_WAIT} pcs_gsw_t;
endpackage : pcs_pkg

// File: inc/pcs_gsw_if.sv
// carrier between the control logic and the glitch-free clock selector
`timescale 1ns/1ns
interface pcs_gsw_if;
    logic [pcs_pkg::NUM_CAND-1:0] cand;
    logic [2:0] sel;
    logic en;
    logic clk_out;
    logic busy;
    modport ctrl (output cand, output sel, output en, input clk_out, input busy);
    modport gen (input cand, input sel, input en, output clk_out, output busy);
endinterface : pcs_gsw_if

// File: verilog/pcs_sync_clk_sel.sv
// glitch-free selector for the synchronous clock output
`timescale 1ns/1ns
module pcs_sync_clk_sel (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    pcs_gsw_if.gen sw
);
    pcs_pkg::pcs_gsw_t st_q;
    logic [2:0] cur_q;
    logic en_q;
    logic out_q;
    wire cur_lvl = sw.cand[cur_q];
    wire new_lvl = sw.cand[sw.sel];
    wire change = (sw.sel != cur_q) || (sw.en != en_q);

    // ------------------------------
    // switch sequence
    // ------------------------------
    // old source is let fall and new one taken only while low: no runt pulse
    always_ff @(posedge clock) begin
        if (rst) begin
            st_q <= pcs_pkg::GS_RUN;
            cur_q <= 3'h0;
            en_q <= 1'b1;
            out_q <= 1'b0;
        end else if (ce) begin
            unique case (st_q)
                pcs_pkg::GS_RUN: begin
                    out_q <= en_q & cur_lvl;
                    if (change) st_q <= pcs_pkg::GS_DRAIN;
                end
                pcs_pkg::GS_DRAIN: begin
                    out_q <= out_q & cur_lvl;
                    if (!cur_lvl) st_q <= pcs_pkg::GS_WAIT;
                end
                pcs_pkg::GS_WAIT: begin
                    out_q <= 1'b0;
                    if (!new_lvl) begin
                        cur_q <= sw.sel;
                        en_q <= sw.en;
                        st_q <= pcs_pkg::GS_RUN;
                    end
                end
                default: st_q <= pcs_pkg::GS_RUN;
            endcase
        end
    end
    assign sw.clk_out = out_q;
    assign sw.busy = st_q != pcs_pkg::GS_RUN;

    // ------------------------------
    // checks
    // ------------------------------
    wait_low_a: assert property (@(posedge clock) disable iff (rst)
        st_q == pcs_pkg::GS_WAIT && ce |=> !out_q)
        else $error("sync clock not held low while switching");
    no_rise_switch_a: assert property (@(posedge clock) disable iff (rst)
        $rose(out_q) |-> $past(st_q) == pcs_pkg::GS_RUN)
        else $error("sync clock rose during a source switch");
    off_stays_low_a: assert property (@(posedge clock) disable iff (rst)
        st_q == pcs_pkg::GS_RUN && !en_q && ce |=> !out_q)
        else $error("disabled sync clock toggled");
endmodule : pcs_sync_clk_sel

// File: verif/pcs_p6_partner.sv
// port-6 link partner model: drives the clocks the device expects as inputs
`timescale 1ns/1ns
module pcs_p6_partner (
    input wire logic [2:0] need,
    input wire logic [1:0] dev_oe,
    input wire logic [1:0] dev_clk,
    output logic rx_wire,
    output logic tx_wire,
    output logic ref_wire
);
    // ------------------------------
    // link clock and pin levels
    // ------------------------------
    logic lclk = 1'h0;
    logic [2:0] rel = 3'h0;
    // free running like a real partner, phase unrelated to the core clock
    initial begin
        #130;
        forever #400 lclk = ~lclk;
    end
    // a released line holds nothing we can trust, so it shows the opposite level
    always @(need) rel = ~{3{lclk}};
    assign rx_wire = dev_oe[0] ? dev_clk[0] : (need[0] ? lclk : rel[0]);
    assign tx_wire = dev_oe[1] ? dev_clk[1] : (need[1] ? lclk : rel[1]);
    assign ref_wire = need[2] ? lclk : rel[2];
endmodule : pcs_p6_partner

// File: verif/port_clock_sourcing_tb_top.sv
// self-checking testbench for port clock sourcing
`timescale 1ns/1ns
module port_clock_sourcing_tb_top;
    // ------------------------------
    // stimulus, dut and partner
    // ------------------------------
    logic clock = 1'h0;
    logic rst = 1'h1;
    logic hsel = 1'h0;
    logic hwrite = 1'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic osc_in = 1'h0;
    logic osc_run = 1'h1;
    logic mgmt_clk = 1'h0;
    logic [4:0] phy_rec = 5'h0;
    logic [1:0] s_mode = 2'h0;
    logic s_role = 1'h0;
    logic s_cm = 1'h0;
    logic s_gig = 1'h0;
    logic [2:0] need = 3'h0;
    wire hready, hresp, osc_out, rx_out, rx_oe, tx_out, tx_oe, ref_out, sync_out;
    wire clk_ok, tick, in_rise, mg_rise, rx_w, tx_w, ref_w;
    wire [31:0] hrdata;
    wire [6:0] mon = {mg_rise, tick, sync_out, in_rise, ref_out, tx_out, rx_out};
    int errors = 0;
    int num_checks = 0;
    initial forever #50 clock = ~clock;
    // reference scaled to 400 ns, the real rate is out of reach of a 10 MHz core
    initial forever #200 if (osc_run) osc_in = ~osc_in;
    initial forever #500 mgmt_clk = ~mgmt_clk;
    for (genvar i = 0; i < 5; i++) begin : g_rec
        initial forever #((i + 3) * 100 + 7) phy_rec[i] = ~phy_rec[i];
    end
    pcs_port_clock_top dut_u (.clock(clock), .rst(rst), .ce(1'h1), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
        .osc_in(osc_in), .osc_out(osc_out), .p6_receive_clock_in(rx_w),
        .p6_receive_clock_out(rx_out), .p6_receive_clock_oe(rx_oe),
        .p6_transmit_clock_in(tx_w), .p6_transmit_clock_out(tx_out),
        .p6_transmit_clock_oe(tx_oe), .p6_rmii_ref_input(ref_w),
        .p6_rmii_ref_output(ref_out), .mgmt_clock_in(mgmt_clk),
        .phy_recovered_clock(phy_rec), .strap_p6_mode(s_mode), .strap_mii_phy_role(s_role),
        .strap_rmii_clock_mode(s_cm), .strap_rgmii_gig(s_gig),
        .sync_ether_clock_out(sync_out), .core_clock_ok(clk_ok), .ref_tick(tick),
        .p6_in_clock_rise(in_rise), .mgmt_clock_rise(mg_rise));
    pcs_p6_partner part_u (.need(need), .dev_oe({tx_oe, rx_oe}), .dev_clk({tx_out, rx_out}),
        .rx_wire(rx_w), .tx_wire(tx_w), .ref_wire(ref_w));
    // ------------------------------
    // shared tasks
    // ------------------------------
    task automatic check(input string what, input int tol, input logic [31:0] exp,
        input logic [31:0] seen);
        logic bad;
        num_checks++;
        if (tol == 0)
            bad = seen !== exp;
        else
            bad = $isunknown(seen) || seen > exp + tol || seen + tol < exp;
        if (bad) begin
            errors++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test
    task automatic cycles(input int n);
        repeat (n) @(posedge clock);
    endtask : cycles
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge clock);
        while (hready !== 1'h1) begin
            n++;
            if (n > 50) begin
                errors++;
                end_of_test();
            end
            @(posedge clock);
        end
    endtask : wait_rdy
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        wait_rdy();
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        r = hrdata;
        check("bus response", 0, 32'h0, {31'h0, hresp});
    endtask : xfer
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp,
        input string what);
        logic [31:0] r;
        xfer(1'h0, a, 32'h0, r);
        check(what, 0, exp, r & m);
    endtask : rd_chk
    // rising edges of one monitored output over 400 core cycles
    task automatic count(input int sel, output int c);
        logic prev;
        c = 0;
        prev = mon[sel];
        repeat (400) begin
            @(posedge clock);
            if (mon[sel] === 1'h1 && prev === 1'h0) c++;
            prev = mon[sel];
        end
    endtask : count
    task automatic do_reset(input logic [1:0] m, input logic role, input logic cm,
        input logic gig);
        rst <= 1'h1;
        s_mode <= m;
        s_role <= role;
        s_cm <= cm;
        s_gig <= gig;
        cycles(5);
        rst <= 1'h0;
        cycles(6);
    endtask : do_reset
    // ------------------------------
    // scenarios
    // ------------------------------
    // half: driven receive clock half period, 0 when the pin is an input
    task automatic p6_case(input logic [1:0] m, input logic role, input logic cm,
        input logic gig, input logic slow, input logic [2:0] nd, input logic [1:0] oe,
        input int half, input int ref_exp, input int in_exp);
        logic [31:0] r;
        logic [31:0] st;
        int c;
        need <= nd;
        do_reset(m, role, cm, gig);
        st = {24'h0, gig, cm, role, m[1] ? 2'h2 : m, 3'h1};
        check("port clock enables", 0, oe, {tx_oe, rx_oe});
        if (slow) xfer(1'h1, pcs_pkg::ADDR_P6_CTRL, 32'h1, r);
        rd_chk(pcs_pkg::ADDR_STATUS, 32'h1ff, st, "strap status");
        s_mode <= ~m;
        s_role <= ~role;
        s_cm <= ~cm;
        s_gig <= ~gig;
        rd_chk(pcs_pkg::ADDR_STATUS, 32'h1ff, st, "held strap status");
        if (half > 0) begin
            count(0, c);
            check("receive clock edges", 1, 200 / half, c);
        end
        if (oe[1]) begin
            count(1, c);
            check("transmit clock edges", 1, 200 / half, c);
        end
        count(2, c);
        check("rmii reference edges", 1, ref_exp, c);
        count(3, c);
        check("input clock edges", 1, in_exp, c);
        $display("test port6 mode %0d done", m);
    endtask : p6_case
    task automatic sync_case(input logic [4:0] ctrl, input int exp, input int tol);
        logic [31:0] r;
        int c;
        xfer(1'h1, pcs_pkg::ADDR_OUT_CLK, {27'h0, ctrl}, r);
        // every call but the first changes the control, so a hand-over is under way
        rd_chk(pcs_pkg::ADDR_STATUS, 32'h100, {23'h0, ctrl != 5'h01, 8'h0},
            "switch busy");
        rd_chk(pcs_pkg::ADDR_OUT_CLK, 32'h1f, {27'h0, ctrl}, "clock control");
        // leave time for the selector to finish its hand-over
        cycles(40);
        count(4, c);
        check("sync clock edges", tol, exp, c);
    endtask : sync_case
    task automatic reg_sync_test;
        logic [31:0] r;
        need <= 3'h3;
        do_reset(2'h0, 1'h0, 1'h0, 1'h0);
        rd_chk(pcs_pkg::ADDR_OUT_CLK, 32'hffffffff, 32'h1, "clock control reset");
        rd_chk(pcs_pkg::ADDR_P6_CTRL, 32'hffffffff, 32'h0, "port6 control reset");
        xfer(1'h1, 8'h0c, 32'hffffffff, r);
        rd_chk(8'h0c, 32'hffffffff, 32'h0, "unmapped offset");
        sync_case(5'h01, 100, 2);
        sync_case(5'h03, 200, 1);
        sync_case(5'h00, 0, 0);
        for (int n = 1; n < 6; n++) begin
            sync_case({n[2:0], 2'h1}, 20000 / ((n + 2) * 100 + 7), 2);
        end
        sync_case(5'h19, 100, 2);
        $display("test sync clock done");
    endtask : reg_sync_test
    task automatic ref_test;
        int c;
        count(5, c);
        check("reference ticks", 1, 100, c);
        count(6, c);
        check("management clock edges", 1, 40, c);
        check("crystal drive", 0, {31'h0, ~osc_in}, {31'h0, osc_out});
        check("reference ok", 0, 32'h1, {31'h0, clk_ok});
        osc_run <= 1'h0;
        cycles(30);
        check("reference lost", 0, 32'h0, {31'h0, clk_ok});
        rd_chk(pcs_pkg::ADDR_STATUS, 32'h200, 32'h0, "status reference");
        osc_run <= 1'h1;
        cycles(20);
        check("reference back", 0, 32'h1, {31'h0, clk_ok});
        $display("test reference done");
    endtask : ref_test
    initial begin
        p6_case(2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 3'h3, 2'h0, 0, 0, 50);
        p6_case(2'h0, 1'h1, 1'h0, 1'h0, 1'h0, 3'h0, 2'h3, pcs_pkg::HALF_100, 0, 0);
        p6_case(2'h0, 1'h1, 1'h0, 1'h0, 1'h1, 3'h0, 2'h3, pcs_pkg::HALF_10, 0, 0);
        p6_case(2'h1, 1'h0, 1'h0, 1'h0, 1'h0, 3'h4, 2'h0, 0, 0, 50);
        p6_case(2'h1, 1'h0, 1'h1, 1'h0, 1'h0, 3'h0, 2'h0, 0,
            200 / pcs_pkg::HALF_RMII, 0);
        p6_case(2'h2, 1'h0, 1'h0, 1'h1, 1'h0, 3'h2, 2'h1, pcs_pkg::HALF_GIG, 0, 50);
        p6_case(2'h2, 1'h0, 1'h0, 1'h0, 1'h0, 3'h2, 2'h1, pcs_pkg::HALF_100, 0, 50);
        p6_case(2'h3, 1'h0, 1'h0, 1'h1, 1'h1, 3'h2, 2'h1, pcs_pkg::HALF_10, 0, 50);
        reg_sync_test();
        ref_test();
        end_of_test();
    end
endmodule : port_clock_sourcing_tb_top
